// >>> verilog/pllm_pkg.sv
// package: register map, field layout and carrier types of the synthesizer config block
package pllm_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_SRST = 8'h00;
  localparam logic [7:0] IDX_FRAC = 8'h04;
  localparam logic [7:0] IDX_SEED = 8'h05;
  localparam logic [7:0] IDX_MOD  = 8'h06;
  localparam logic [7:0] IDX_LKD  = 8'h07;
  localparam logic [7:0] IDX_EN   = 8'h08;
  localparam int         SRST_BIT = 0;
  // modulator_config fields
  localparam int         MOD_ORD_LSB  = 8;
  localparam int         MOD_FRAC_RB  = 10;
  localparam int         MOD_BUF_RB   = 11;
  localparam int         MOD_BYPASS   = 12;
  localparam int         MOD_AUTOSEED = 13;
  localparam int         MOD_FSK      = 15;
  localparam int         MOD_CLK_REF  = 17;
  localparam int         MOD_CLK_INV  = 18;
  localparam int         MOD_CSP_LSB  = 20;
  localparam logic [1:0] ORDER_B      = 2'h2;
  localparam logic [1:0] ORDER_A      = 2'h3;
  // lock_detect_slip_config fields
  localparam int         LKD_WIN_LSB  = 0;
  localparam int         LKD_EN       = 10;
  localparam int         LKD_ASYM     = 11;
  localparam int         LKD_LEAD     = 12;
  localparam int         LKD_RING_OS  = 13;
  localparam int         LKD_DUR_LSB  = 14;
  localparam int         LKD_TRIM_LSB = 17;
  localparam int         LKD_RING_ON  = 19;
  localparam int         LKD_CSP      = 20;
  // block_enables fields
  localparam int         EN_BIAS      = 0;
  localparam int         EN_PUMP      = 1;
  localparam int         EN_DETECT    = 2;
  localparam int         EN_REF_BUF   = 3;
  localparam int         EN_VCO_BUF   = 4;
  localparam int         EN_GP_PADS   = 5;
  localparam int         EN_SDO_PAD   = 6;
  localparam int         EN_DIVCLK    = 7;
  localparam int         EN_VCO_DIV   = 8;
  localparam int         EN_STRETCH   = 10;
  localparam int         EN_RAW_REF   = 12;
  localparam int         EN_DIV_REF   = 13;
  localparam logic [15:0] STRETCH_MIN_N = 16'h0020;
  // reset values
  localparam logic [23:0] MOD_RST  = 24'h842E87;
  localparam logic [20:0] LKD_RST  = 21'h1007FF;
  localparam logic [13:0] EN_RST   = 14'h31FF;
  localparam logic [23:0] FRAC_RST = 24'h000000;
  localparam logic [23:0] SEED_RST = 24'h000000;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [9:0]  paddr;
    logic [31:0] pwdata;
  } pllm_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } pllm_apb_rsp_t;

  typedef struct packed {
    logic        variant_b;
    logic        variant_a;
    logic        core_rst;
    logic        buf_rst;
    logic        bypass;
    logic        fsk_mode;
    logic        clk_from_ref;
    logic        clk_invert;
    logic [3:0]  csp_mag;
    logic        seed_load;
    logic [23:0] seed;
  } pllm_mod_t;

  typedef struct packed {
    logic       detect_on;
    logic       win_asym;
    logic       win_lead;
    logic       ring_oneshot;
    logic [2:0] oneshot_dur;
    logic [1:0] ring_trim;
    logic       ring_force;
    logic       csp_on;
  } pllm_lkd_t;

  typedef struct packed {
    logic bias_on;
    logic charge_pump_on;
    logic detector_on;
    logic ref_buf_on;
    logic vco_buf_on;
    logic gp_pads_on;
    logic serial_out_pad_on;
    logic divclk_to_logic_on;
    logic vco_div_on;
    logic div_stretch;
    logic raw_reference_to_logic;
    logic divided_reference_to_logic;
  } pllm_en_t;
endpackage

// >>> verilog/pllm_sync3.sv
// three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module pllm_sync3 (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // pin in, clean level out
  input  wire logic i_d,
  output logic      o_q
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } pllm_sync_t;

  pllm_sync_t st_reg;
  pllm_sync_t st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = i_d;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    if (st_reg.s2 == st_reg.s3) begin
      st_next.q = st_reg.s3;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_q = st_reg.q;
endmodule

// >>> verilog/pllm_lockcnt.sv
// lock detector: counts consecutive divided-vco edges inside the window
`timescale 1ns/1ps
module pllm_lockcnt (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // control
  input  wire logic       i_clear,
  input  wire logic [9:0] i_max,
  // detector events
  input  wire logic       i_edge,
  input  wire logic       i_in_win,
  // result
  output logic            o_lock
);
  typedef struct packed {
    logic [9:0] cnt;
    logic       lock;
  } pllm_lk_t;

  pllm_lk_t st_reg;
  pllm_lk_t st_next;

  always_comb begin
    st_next = st_reg;
    if (i_clear) begin
      st_next = '0;
    end else if (i_edge && !i_in_win) begin
      st_next = '0;
    end else if (i_edge) begin
      if (st_reg.cnt != i_max) begin
        st_next.cnt = st_reg.cnt + 10'h001;
      end
      st_next.lock = st_reg.lock | (st_next.cnt == i_max);
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_lock = st_reg.lock;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  AST_LOCK_AT_COUNT: assert property ($rose(o_lock) |-> st_reg.cnt == i_max)
    else $error("lock declared before window count reached");
  AST_LOCK_DROP: assert property (i_edge && !i_in_win && !i_clear |=> !o_lock)
    else $error("lock kept after edge outside window");
  CV_LOCK: cover property ($rose(o_lock));
endmodule

// >>> verilog/pllm_cfg.sv
// synthesizer modulator, lock-detect and block-enable configuration registers on apb
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
module pllm_cfg (
  // clock and reset
  input  wire logic                  I_CLK,
  input  wire logic                  I_RST,
  // apb slave
  input  wire pllm_pkg::pllm_apb_req_t I_APB,
  output pllm_pkg::pllm_apb_rsp_t    O_APB,
  // modulator side
  input  wire logic [23:0]           I_MOD_OUT,
  input  wire logic                  I_REFDIV_CLK,
  input  wire logic                  I_VCODIV_CLK,
  input  wire logic [15:0]           I_DIV_RATIO,
  output pllm_pkg::pllm_mod_t        O_MOD,
  output logic [23:0]                O_DIV_FRAC,
  output logic                       O_MOD_CLK,
  // keying
  input  wire logic                  I_SERIAL_IN_PIN,
  output logic                       O_KEY,
  // lock detector
  input  wire logic                  I_DIV_EDGE,
  input  wire logic                  I_IN_WINDOW,
  input  wire logic                  I_LOCK_FLAG_OUTPUT_ON,
  output pllm_pkg::pllm_lkd_t        O_LKD,
  output logic                       O_LOCK,
  output logic                       O_LOCK_SERIAL_OUT_PIN,
  // block enables
  output pllm_pkg::pllm_en_t         O_EN
);
  typedef struct packed {
    logic [23:0] modc;
    logic [20:0] lkd;
    logic [13:0] en;
    logic [23:0] frac;
    logic [23:0] seed;
    logic [31:0] prdata;
    logic        pslverr;
    logic        seed_load;
    logic        soft_rst;
    logic [23:0] div_frac;
    logic        stretch;
    logic        key;
    logic        ld_pin;
  } pllm_state_t;

  pllm_state_t st_reg;
  pllm_state_t st_next;
  logic [7:0]  idx;
  logic        setup;
  logic        wr;
  logic        hit;
  logic        key_sync;
  logic        lock;

  assign idx   = I_APB.paddr[9:2];
  assign setup = I_APB.psel && !I_APB.penable;
  assign wr    = I_APB.psel && I_APB.penable && I_APB.pwrite;

  always_comb begin
    hit = 1'b1;
    case (idx)
      pllm_pkg::IDX_SRST: hit = 1'b1;
      pllm_pkg::IDX_FRAC: hit = 1'b1;
      pllm_pkg::IDX_SEED: hit = 1'b1;
      pllm_pkg::IDX_MOD:  hit = 1'b1;
      pllm_pkg::IDX_LKD:  hit = 1'b1;
      pllm_pkg::IDX_EN:   hit = 1'b1;
      default:            hit = 1'b0;
    endcase
  end

  pllm_sync3 u_key_sync (
    .i_clk (I_CLK),
    .i_rst (I_RST),
    .i_d   (I_SERIAL_IN_PIN),
    .o_q   (key_sync)
  );

  pllm_lockcnt u_lock (
    .i_clk    (I_CLK),
    .i_rst    (I_RST),
    .i_clear  (!st_reg.lkd[pllm_pkg::LKD_EN] || st_reg.soft_rst),
    .i_max    (st_reg.lkd[pllm_pkg::LKD_WIN_LSB +: 10]),
    .i_edge   (I_DIV_EDGE),
    .i_in_win (I_IN_WINDOW),
    .o_lock   (lock)
  );

  always_comb begin
    st_next           = st_reg;
    st_next.seed_load = 1'b0;
    st_next.soft_rst  = 1'b0;
    // soft reset returns every register to its default
    if (st_reg.soft_rst) begin
      st_next.modc = pllm_pkg::MOD_RST;
      st_next.lkd  = pllm_pkg::LKD_RST;
      st_next.en   = pllm_pkg::EN_RST;
      st_next.frac = pllm_pkg::FRAC_RST;
      st_next.seed = pllm_pkg::SEED_RST;
    end
    // read data and error latched in setup, shown in access;
    // taken from the next state so a setup right after a soft reset reads defaults
    if (setup) begin
      st_next.pslverr = !hit;
      st_next.prdata  = 32'h00000000;
      if (!I_APB.pwrite) begin
        case (idx)
          pllm_pkg::IDX_FRAC: st_next.prdata = {8'h00, st_next.frac};
          pllm_pkg::IDX_SEED: st_next.prdata = {8'h00, st_next.seed};
          pllm_pkg::IDX_MOD:  st_next.prdata = {8'h00, st_next.modc};
          pllm_pkg::IDX_LKD:  st_next.prdata = {11'h000, st_next.lkd};
          pllm_pkg::IDX_EN:   st_next.prdata = {18'h00000, st_next.en};
          default:            st_next.prdata = 32'h00000000;
        endcase
      end
    end
    if (wr) begin
      case (idx)
        pllm_pkg::IDX_SRST: st_next.soft_rst = I_APB.pwdata[pllm_pkg::SRST_BIT];
        pllm_pkg::IDX_FRAC: begin
          st_next.frac      = I_APB.pwdata[23:0];
          st_next.seed_load = st_reg.modc[pllm_pkg::MOD_AUTOSEED];
        end
        pllm_pkg::IDX_SEED: st_next.seed = I_APB.pwdata[23:0];
        pllm_pkg::IDX_MOD:  st_next.modc = I_APB.pwdata[23:0];
        pllm_pkg::IDX_LKD:  st_next.lkd  = I_APB.pwdata[20:0];
        pllm_pkg::IDX_EN:   st_next.en   = I_APB.pwdata[13:0];
        default:            st_next.pslverr = 1'b1;
      endcase
    end
    // bypass drops the modulator word toward the divider
    st_next.div_frac = st_reg.modc[pllm_pkg::MOD_BYPASS] ? 24'h000000 : I_MOD_OUT;
    st_next.stretch  = st_reg.en[pllm_pkg::EN_STRETCH]
                       && (I_DIV_RATIO > pllm_pkg::STRETCH_MIN_N);
    st_next.key      = st_reg.modc[pllm_pkg::MOD_FSK] && key_sync;
    st_next.ld_pin   = lock && I_LOCK_FLAG_OUTPUT_ON
                       && st_reg.en[pllm_pkg::EN_SDO_PAD];
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      st_reg      <= '0;
      st_reg.modc <= pllm_pkg::MOD_RST;
      st_reg.lkd  <= pllm_pkg::LKD_RST;
      st_reg.en   <= pllm_pkg::EN_RST;
      st_reg.frac <= pllm_pkg::FRAC_RST;
      st_reg.seed <= pllm_pkg::SEED_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // apb answer: zero wait states
  assign O_APB.prdata  = st_reg.prdata;
  assign O_APB.pready  = 1'b1;
  assign O_APB.pslverr = st_reg.pslverr;

  // modulator controls
  assign O_MOD.variant_b    = st_reg.modc[pllm_pkg::MOD_ORD_LSB +: 2] == pllm_pkg::ORDER_B;
  assign O_MOD.variant_a    = st_reg.modc[pllm_pkg::MOD_ORD_LSB +: 2] == pllm_pkg::ORDER_A;
  assign O_MOD.core_rst     = !st_reg.modc[pllm_pkg::MOD_FRAC_RB];
  assign O_MOD.buf_rst      = !st_reg.modc[pllm_pkg::MOD_BUF_RB];
  assign O_MOD.bypass       = st_reg.modc[pllm_pkg::MOD_BYPASS];
  assign O_MOD.fsk_mode     = st_reg.modc[pllm_pkg::MOD_FSK];
  assign O_MOD.clk_from_ref = st_reg.modc[pllm_pkg::MOD_CLK_REF];
  assign O_MOD.clk_invert   = st_reg.modc[pllm_pkg::MOD_CLK_INV];
  assign O_MOD.csp_mag      = st_reg.modc[pllm_pkg::MOD_CSP_LSB +: 4];
  assign O_MOD.seed_load    = st_reg.seed_load;
  assign O_MOD.seed         = st_reg.seed;
  assign O_DIV_FRAC         = st_reg.div_frac;
  // modulator clock mux and inversion; keeps running under bypass
  assign O_MOD_CLK = (st_reg.modc[pllm_pkg::MOD_CLK_REF] ? I_REFDIV_CLK : I_VCODIV_CLK)
                     ^ st_reg.modc[pllm_pkg::MOD_CLK_INV];
  assign O_KEY     = st_reg.key;

  // lock detector controls
  assign O_LKD.detect_on    = st_reg.lkd[pllm_pkg::LKD_EN];
  assign O_LKD.win_asym     = st_reg.lkd[pllm_pkg::LKD_ASYM];
  assign O_LKD.win_lead     = st_reg.lkd[pllm_pkg::LKD_LEAD];
  assign O_LKD.ring_oneshot = st_reg.lkd[pllm_pkg::LKD_RING_OS];
  assign O_LKD.oneshot_dur  = st_reg.lkd[pllm_pkg::LKD_DUR_LSB +: 3];
  assign O_LKD.ring_trim    = st_reg.lkd[pllm_pkg::LKD_TRIM_LSB +: 2];
  assign O_LKD.ring_force   = st_reg.lkd[pllm_pkg::LKD_RING_ON];
  assign O_LKD.csp_on       = st_reg.lkd[pllm_pkg::LKD_CSP];
  assign O_LOCK                = lock;
  assign O_LOCK_SERIAL_OUT_PIN = st_reg.ld_pin;

  // block enables
  assign O_EN.bias_on                    = st_reg.en[pllm_pkg::EN_BIAS];
  assign O_EN.charge_pump_on             = st_reg.en[pllm_pkg::EN_PUMP];
  assign O_EN.detector_on                = st_reg.en[pllm_pkg::EN_DETECT];
  assign O_EN.ref_buf_on                 = st_reg.en[pllm_pkg::EN_REF_BUF];
  assign O_EN.vco_buf_on                 = st_reg.en[pllm_pkg::EN_VCO_BUF];
  assign O_EN.gp_pads_on                 = st_reg.en[pllm_pkg::EN_GP_PADS];
  assign O_EN.serial_out_pad_on          = st_reg.en[pllm_pkg::EN_SDO_PAD];
  assign O_EN.divclk_to_logic_on         = st_reg.en[pllm_pkg::EN_DIVCLK];
  assign O_EN.vco_div_on                 = st_reg.en[pllm_pkg::EN_VCO_DIV];
  assign O_EN.div_stretch                = st_reg.stretch;
  assign O_EN.raw_reference_to_logic     = st_reg.en[pllm_pkg::EN_RAW_REF];
  assign O_EN.divided_reference_to_logic = st_reg.en[pllm_pkg::EN_DIV_REF];

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  logic wr_mod;
  assign wr_mod = wr && idx == pllm_pkg::IDX_MOD;

  AST_MOD_TYPE: assert property (wr_mod |=>
      O_MOD.variant_b == ($past(I_APB.pwdata[pllm_pkg::MOD_ORD_LSB +: 2]) == pllm_pkg::ORDER_B))
    else $error("modulator variant does not follow written order");
  AST_CORE_HOLD: assert property (wr_mod && !I_APB.pwdata[pllm_pkg::MOD_FRAC_RB]
      |=> O_MOD.core_rst)
    else $error("core not held after clearing its hold bit");
  AST_BUF_HOLD: assert property (wr_mod && I_APB.pwdata[pllm_pkg::MOD_BUF_RB]
      |=> !O_MOD.buf_rst)
    else $error("buffers still held after release");
  AST_BYPASS: assert property (O_MOD.bypass && $stable(O_MOD.bypass) |=> O_DIV_FRAC == 24'h000000)
    else $error("modulator word passed under bypass");
  AST_AUTOSEED: assert property (wr && idx == pllm_pkg::IDX_FRAC
      && st_reg.modc[pllm_pkg::MOD_AUTOSEED] && !st_reg.soft_rst |=> O_MOD.seed_load ##1 !O_MOD.seed_load)
    else $error("seed load pulse missing after fraction write");
  AST_KEY_OFF: assert property (!O_MOD.fsk_mode |=> !O_KEY)
    else $error("key active outside keying mode");
  AST_LD_PIN: assert property (O_LOCK_SERIAL_OUT_PIN |->
      $past(O_LOCK && O_EN.serial_out_pad_on && I_LOCK_FLAG_OUTPUT_ON))
    else $error("lock pin driven without its enables");
  AST_STRETCH: assert property (O_EN.div_stretch |-> $past(I_DIV_RATIO) > pllm_pkg::STRETCH_MIN_N)
    else $error("stretch at ratio not above limit");
  AST_READBACK: assert property (I_APB.psel && I_APB.penable && !I_APB.pwrite
      && idx == pllm_pkg::IDX_MOD |-> O_APB.prdata == {8'h00, st_reg.modc})
    else $error("modulator config readback mismatch");
  AST_SOFT_RST: assert property (st_reg.soft_rst |=> st_reg.en == pllm_pkg::EN_RST
      && st_reg.modc == pllm_pkg::MOD_RST)
    else $error("soft reset did not restore defaults");
  AST_CSP_MAG: assert property (wr_mod |=>
      O_MOD.csp_mag == $past(I_APB.pwdata[pllm_pkg::MOD_CSP_LSB +: 4]))
    else $error("slip correction magnitude does not follow write");
  AST_CLK_SEL: assert property (wr_mod |=>
      O_MOD.clk_from_ref == $past(I_APB.pwdata[pllm_pkg::MOD_CLK_REF])
      && O_MOD.clk_invert == $past(I_APB.pwdata[pllm_pkg::MOD_CLK_INV]))
    else $error("modulator clock select or inversion does not follow write");
  AST_DIV_PASS: assert property (!O_MOD.bypass |=> O_DIV_FRAC == $past(I_MOD_OUT))
    else $error("modulator word not passed to divider");
  AST_SEED_WR: assert property (wr && idx == pllm_pkg::IDX_SEED |=>
      O_MOD.seed == $past(I_APB.pwdata[23:0]))
    else $error("seed value does not follow write");
  AST_LKD_WR: assert property (wr && idx == pllm_pkg::IDX_LKD |=>
      O_LKD.win_asym == $past(I_APB.pwdata[pllm_pkg::LKD_ASYM])
      && O_LKD.win_lead == $past(I_APB.pwdata[pllm_pkg::LKD_LEAD])
      && O_LKD.csp_on == $past(I_APB.pwdata[pllm_pkg::LKD_CSP]))
    else $error("lock window or slip enable does not follow write");
  AST_REF_FEED: assert property (wr && idx == pllm_pkg::IDX_EN |=>
      O_EN.raw_reference_to_logic == $past(I_APB.pwdata[pllm_pkg::EN_RAW_REF])
      && O_EN.divided_reference_to_logic == $past(I_APB.pwdata[pllm_pkg::EN_DIV_REF]))
    else $error("reference feed enables do not follow write");
  AST_NO_STRETCH: assert property (!st_reg.en[pllm_pkg::EN_STRETCH] |=> !O_EN.div_stretch)
    else $error("stretch active with duty mode off");
  AST_UNMAPPED: assert property (I_APB.psel && I_APB.penable && !hit |->
      O_APB.pslverr && O_APB.prdata == 32'h00000000)
    else $error("unmapped access not refused");
  CV_FRAC_MODE: cover property (wr_mod ##1 !O_MOD.bypass && !O_MOD.core_rst && !O_MOD.buf_rst);
  CV_AUTOSEED: cover property (O_MOD.seed_load);
  CV_LOCK_PIN: cover property ($rose(O_LOCK_SERIAL_OUT_PIN));
endmodule

// >>> sim/tb.sv
// self-checking bench for the synthesizer configuration register block
`timescale 1ns/1ps
module tb;
  logic                    I_CLK;
  logic                    I_RST;
  pllm_pkg::pllm_apb_req_t I_APB;
  pllm_pkg::pllm_apb_rsp_t O_APB;
  logic [23:0]             I_MOD_OUT;
  logic                    I_REFDIV_CLK;
  logic                    I_VCODIV_CLK;
  logic [15:0]             I_DIV_RATIO;
  pllm_pkg::pllm_mod_t     O_MOD;
  logic [23:0]             O_DIV_FRAC;
  logic                    O_MOD_CLK;
  logic                    I_SERIAL_IN_PIN;
  logic                    O_KEY;
  logic                    I_DIV_EDGE;
  logic                    I_IN_WINDOW;
  logic                    I_LOCK_FLAG_OUTPUT_ON;
  pllm_pkg::pllm_lkd_t     O_LKD;
  logic                    O_LOCK;
  logic                    O_LOCK_SERIAL_OUT_PIN;
  pllm_pkg::pllm_en_t      O_EN;
  int                      n_fail;
  int                      n_checks;
  int                      cycles;
  logic [31:0]             seed_st;
  logic [31:0]             rd;
  logic                    err;
  logic [23:0]             vm;
  logic [20:0]             vl;
  logic [13:0]             ve;

  pllm_cfg dut_u (
    .I_CLK(I_CLK), .I_RST(I_RST), .I_APB(I_APB), .O_APB(O_APB), .I_MOD_OUT(I_MOD_OUT),
    .I_REFDIV_CLK(I_REFDIV_CLK), .I_VCODIV_CLK(I_VCODIV_CLK), .I_DIV_RATIO(I_DIV_RATIO),
    .O_MOD(O_MOD), .O_DIV_FRAC(O_DIV_FRAC), .O_MOD_CLK(O_MOD_CLK),
    .I_SERIAL_IN_PIN(I_SERIAL_IN_PIN), .O_KEY(O_KEY), .I_DIV_EDGE(I_DIV_EDGE),
    .I_IN_WINDOW(I_IN_WINDOW), .I_LOCK_FLAG_OUTPUT_ON(I_LOCK_FLAG_OUTPUT_ON), .O_LKD(O_LKD),
    .O_LOCK(O_LOCK), .O_LOCK_SERIAL_OUT_PIN(O_LOCK_SERIAL_OUT_PIN), .O_EN(O_EN)
  );

  initial begin
    I_CLK = 1'b0;
    forever #2.5 I_CLK = ~I_CLK;
  end

  function automatic logic [31:0] rnd();
    seed_st = seed_st ^ (seed_st << 13);
    seed_st = seed_st ^ (seed_st >> 17);
    seed_st = seed_st ^ (seed_st << 5);
    return seed_st;
  endfunction

  function automatic logic [11:0] exp_mod(input logic [23:0] v);
    return {v[9:8] == 2'h2, v[9:8] == 2'h3, ~v[10], ~v[11], v[12], v[15], v[17], v[18], v[23:20]};
  endfunction

  function automatic logic [10:0] exp_lkd(input logic [20:0] v);
    return {v[10], v[11], v[12], v[13], v[16:14], v[18:17], v[19], v[20]};
  endfunction

  function automatic logic [11:0] exp_en(input logic [13:0] e, input logic [15:0] r);
    return {e[0], e[1], e[2], e[3], e[4], e[5], e[6], e[7], e[8], e[10] & (r > 16'h0020),
            e[12], e[13]};
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge I_CLK);
    I_APB.psel    <= 1'b1;
    I_APB.penable <= 1'b0;
    I_APB.pwrite  <= w;
    I_APB.paddr   <= {idx, 2'b00};
    I_APB.pwdata  <= wd;
    @(posedge I_CLK);
    I_APB.penable <= 1'b1;
    do @(posedge I_CLK); while (O_APB.pready !== 1'b1);
    rd  = O_APB.prdata;
    err = O_APB.pslverr;
    I_APB.psel    <= 1'b0;
    I_APB.penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp, input string what);
    apb(1'b0, idx, 32'h00000000);
    chk({err, rd}, {1'b0, exp}, what);
  endtask

  // one detector edge, then settle time for the flag
  task automatic pulse(input logic inw);
    @(posedge I_CLK);
    I_DIV_EDGE  <= 1'b1;
    I_IN_WINDOW <= inw;
    @(posedge I_CLK);
    I_DIV_EDGE  <= 1'b0;
    @(posedge I_CLK);
    #1;
  endtask

  task automatic outs(input logic [23:0] m, input logic [20:0] l, input logic [13:0] e);
    chk({O_MOD.variant_b, O_MOD.variant_a, O_MOD.core_rst, O_MOD.buf_rst, O_MOD.bypass,
         O_MOD.fsk_mode, O_MOD.clk_from_ref, O_MOD.clk_invert, O_MOD.csp_mag},
        exp_mod(m), "modulator fields");
    chk(O_LKD, exp_lkd(l), "lock fields");
    chk(O_EN, exp_en(e, I_DIV_RATIO), "enables");
    chk(O_MOD_CLK, (m[17] ? I_REFDIV_CLK : I_VCODIV_CLK) ^ m[18], "mod clock");
    chk(O_KEY, m[15] & I_SERIAL_IN_PIN, "key");
  endtask

  always @(posedge I_CLK) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_fail++;
      test_done();
    end
  end

  initial begin
    seed_st = 32'd62304;
    n_fail = 0;
    n_checks = 0;
    cycles = 0;
    I_RST = 1'b1;
    I_APB = '0;
    I_MOD_OUT = 24'h000000;
    {I_REFDIV_CLK, I_VCODIV_CLK, I_SERIAL_IN_PIN, I_DIV_EDGE, I_IN_WINDOW} = 5'h00;
    I_LOCK_FLAG_OUTPUT_ON = 1'b1;
    I_DIV_RATIO = 16'h0040;
    repeat (2) @(posedge I_CLK);
    I_RST <= 1'b0;
    @(posedge I_CLK);
    #1;
    outs(pllm_pkg::MOD_RST, pllm_pkg::LKD_RST, pllm_pkg::EN_RST);
    rdchk(pllm_pkg::IDX_MOD, {8'h00, pllm_pkg::MOD_RST}, "mod reset");
    rdchk(pllm_pkg::IDX_LKD, {11'h000, pllm_pkg::LKD_RST}, "lock reset");
    rdchk(pllm_pkg::IDX_EN, {18'h00000, pllm_pkg::EN_RST}, "enable reset");
    rdchk(pllm_pkg::IDX_SRST, 32'h00000000, "strobe reads zero");
    for (int i = 0; i < 5; i++) begin
      apb(i[0], (i < 3) ? 8'(i + 1) : ((i == 3) ? 8'h09 : 8'h3F), 32'hFFFFFFFF);
      chk({err, rd}, {1'b1, 32'h00000000}, "unmapped");
    end
    for (int i = 0; i < 20; i++) begin
      @(posedge I_CLK);
      {I_REFDIV_CLK, I_VCODIV_CLK, I_SERIAL_IN_PIN} <= 3'(rnd());
      I_DIV_RATIO <= 16'h001F + 16'(rnd() % 3);
      vm = (24'(rnd()) & 24'hFFBCFF) | {14'h0000, i[1:0], 8'h00};
      vl = 21'(rnd());
      ve = 14'(rnd()) & 14'h37FF;
      apb(1'b1, pllm_pkg::IDX_MOD, {8'hA5, vm});
      apb(1'b1, pllm_pkg::IDX_LKD, {11'h5A5, vl});
      apb(1'b1, pllm_pkg::IDX_EN, {18'h3C3C3, ve});
      rdchk(pllm_pkg::IDX_MOD, {8'h00, vm}, "mod readback");
      rdchk(pllm_pkg::IDX_LKD, {11'h000, vl}, "lock readback");
      rdchk(pllm_pkg::IDX_EN, {18'h00000, ve}, "enable readback");
      @(posedge I_CLK);
      #1;
      outs(vm, vl, ve);
    end
    apb(1'b1, pllm_pkg::IDX_EN, {18'h00000, pllm_pkg::EN_RST});
    apb(1'b1, pllm_pkg::IDX_MOD, {8'h00, pllm_pkg::MOD_RST});
    vm = 24'(rnd());
    apb(1'b1, pllm_pkg::IDX_SEED, {8'h00, vm});
    apb(1'b1, pllm_pkg::IDX_FRAC, 32'h00123456);
    #1;
    chk(O_MOD.seed_load, 1'b1, "seed load");
    chk(O_MOD.seed, vm, "seed value");
    chk({O_MOD.core_rst, O_MOD.buf_rst, O_MOD.bypass}, 3'h0, "fractional mode");
    @(posedge I_CLK);
    #1;
    chk(O_MOD.seed_load, 1'b0, "seed load pulse");
    apb(1'b1, pllm_pkg::IDX_MOD, {8'h00, pllm_pkg::MOD_RST & 24'hFFDFFF});
    apb(1'b1, pllm_pkg::IDX_FRAC, 32'h00000001);
    #1;
    chk(O_MOD.seed_load, 1'b0, "no seed load");
    rdchk(pllm_pkg::IDX_FRAC, 32'h00000001, "frac readback");
    for (int b = 0; b < 2; b++) begin
      apb(1'b1, pllm_pkg::IDX_MOD, {8'h00, pllm_pkg::MOD_RST | (b[0] ? 24'h001000 : 24'h0)});
      @(posedge I_CLK);
      vm = 24'(rnd());
      I_MOD_OUT <= vm;
      @(posedge I_CLK);
      #1;
      chk(O_DIV_FRAC, b[0] ? 24'h000000 : vm, "divider word");
    end
    // window count 2, detector on
    apb(1'b1, pllm_pkg::IDX_LKD, 32'h00100402);
    pulse(1'b1);
    chk(O_LOCK, 1'b0, "lock after one edge");
    pulse(1'b1);
    chk(O_LOCK, 1'b1, "lock after two edges");
    @(posedge I_CLK);
    #1;
    chk(O_LOCK_SERIAL_OUT_PIN, 1'b1, "lock pin");
    @(posedge I_CLK);
    I_LOCK_FLAG_OUTPUT_ON <= 1'b0;
    repeat (2) @(posedge I_CLK);
    #1;
    chk(O_LOCK_SERIAL_OUT_PIN, 1'b0, "lock pin routing off");
    pulse(1'b0);
    chk(O_LOCK, 1'b0, "out of window");
    apb(1'b1, pllm_pkg::IDX_LKD, 32'h00100000);
    pulse(1'b1);
    chk(O_LOCK, 1'b0, "detector off");
    apb(1'b1, pllm_pkg::IDX_SRST, 32'h00000001);
    repeat (3) @(posedge I_CLK);
    rdchk(pllm_pkg::IDX_MOD, {8'h00, pllm_pkg::MOD_RST}, "soft reset mod");
    rdchk(pllm_pkg::IDX_LKD, {11'h000, pllm_pkg::LKD_RST}, "soft reset lock");
    rdchk(pllm_pkg::IDX_SEED, 32'h00000000, "soft reset seed");
    rdchk(pllm_pkg::IDX_EN, {18'h00000, pllm_pkg::EN_RST}, "soft reset enables");
    // hard reset in mid-run after clearing the enables
    apb(1'b1, pllm_pkg::IDX_EN, 32'h00000000);
    @(posedge I_CLK);
    I_RST <= 1'b1;
    @(posedge I_CLK);
    I_RST <= 1'b0;
    rdchk(pllm_pkg::IDX_EN, {18'h00000, pllm_pkg::EN_RST}, "hard reset enables");
    test_done();
  end
endmodule
